// file: rcf_framer.sv
// Remote command response frame builder, byte stream toward the UART
// Contract
// - A reply starts a frame: 0x7E at offset 0, type 0x97 at offset 3.
// - Each answer of a multi-answer command gets its own frame.
// - Offsets 1-2 hold length MSB first, bytes between length and checksum.
// - Offset 4 echoes the request tag of the original request.
// - Offsets 5-12 hold the responder 64-bit address, MSB first.
// - Offsets 13-14 hold fixed network address 0xFFFE, high byte first.
// - Offset 17 holds status: 0 ok, 1 error, 2 bad command, 3 bad param.
// - Returned data follows from offset 18; length counts its bytes.
// - Last byte is 0xFF minus the byte sum from offset 3 on.
`default_nettype none
module rcf_framer
  import rcf_pkg::*;
#(
  parameter int DATA_MAX = 64
) (
  input wire logic SYS_CLK,
  input wire logic SRST,
  input wire logic RSP_VALID,
  output logic RSP_READY,
  input wire logic [7:0] RSP_TAG,
  input wire logic [63:0] RSP_ADDR,
  input wire logic [15:0] RSP_CMD,
  input wire logic [7:0] RSP_STATUS,
  input wire logic [7:0] RSP_DATA_LEN,
  input wire logic [8*DATA_MAX-1:0] RSP_DATA,
  output logic TX_VALID,
  input wire logic TX_READY,
  output logic [7:0] TX_BYTE,
  output logic TX_LAST
);
  typedef enum logic [2:0] {
    RCF_IDLE = 3'b001,
    RCF_BODY = 3'b010,
    RCF_CSUM = 3'b100
  } rcf_state_t;

  rcf_state_t state_r, state_nxt;
  logic [7:0] ofs_r, ofs_nxt;
  logic [7:0] tag_r, tag_nxt;
  logic [63:0] addr_r, addr_nxt;
  logic [15:0] cmd_r, cmd_nxt;
  logic [7:0] status_r, status_nxt;
  logic [7:0] dlen_r, dlen_nxt;
  logic [8*DATA_MAX-1:0] data_r, data_nxt;
  logic tx_valid_r, tx_valid_nxt;
  logic [7:0] tx_byte_r, tx_byte_nxt;
  logic tx_last_r, tx_last_nxt;
  logic ready_r, ready_nxt;
  logic [15:0] len;
  logic [7:0] byte_sel;
  logic [7:0] sum;
  logic [7:0] csum;
  logic sum_clear;
  logic sum_add;
  logic [7:0] dlen_in;
  logic [7:0] data_idx;
  logic sent;

  assign sent = tx_valid_r && TX_READY;
  assign len = RCF_FIXED_LEN + {8'h00, dlen_r};
  assign dlen_in = (RSP_DATA_LEN > 8'(DATA_MAX)) ? 8'(DATA_MAX) : RSP_DATA_LEN;
  assign data_idx = 8'(ofs_nxt - RCF_OFS_DATA);

  // Byte for the offset about to be presented
  always_comb begin
    byte_sel = 8'h00;
    if (ofs_nxt == RCF_OFS_DELIM) begin
      byte_sel = RCF_DELIM;
    end else if (ofs_nxt == RCF_OFS_LEN_MSB) begin
      byte_sel = len[15:8];
    end else if (ofs_nxt == RCF_OFS_LEN_LSB) begin
      byte_sel = len[7:0];
    end else if (ofs_nxt == RCF_OFS_TYPE) begin
      byte_sel = RCF_TYPE;
    end else if (ofs_nxt == RCF_OFS_TAG) begin
      byte_sel = tag_nxt;
    end else if (ofs_nxt < RCF_OFS_NET) begin
      byte_sel = addr_nxt[8'(8'd7 - 8'(ofs_nxt - RCF_OFS_ADDR)) * 8 +: 8];
    end else if (ofs_nxt == RCF_OFS_NET) begin
      byte_sel = RCF_NET_ADDR[15:8];
    end else if (ofs_nxt == 8'(RCF_OFS_NET + 8'h01)) begin
      byte_sel = RCF_NET_ADDR[7:0];
    end else if (ofs_nxt == RCF_OFS_CMD) begin
      byte_sel = cmd_nxt[15:8];
    end else if (ofs_nxt == 8'(RCF_OFS_CMD + 8'h01)) begin
      byte_sel = cmd_nxt[7:0];
    end else if (ofs_nxt == RCF_OFS_STATUS) begin
      byte_sel = status_nxt;
    end else if (data_idx < 8'(DATA_MAX)) begin
      byte_sel = data_nxt[data_idx*8 +: 8];
    end
  end

  always_comb begin
    state_nxt = state_r;
    ofs_nxt = ofs_r;
    tag_nxt = tag_r;
    addr_nxt = addr_r;
    cmd_nxt = cmd_r;
    status_nxt = status_r;
    dlen_nxt = dlen_r;
    data_nxt = data_r;
    tx_valid_nxt = tx_valid_r;
    tx_byte_nxt = tx_byte_r;
    tx_last_nxt = tx_last_r;
    ready_nxt = ready_r;
    sum_clear = 1'b0;
    sum_add = 1'b0;
    unique case (state_r)
      RCF_IDLE: begin
        // One frame per accepted answer, never merged
        if (RSP_VALID && ready_r) begin
          tag_nxt = RSP_TAG;
          addr_nxt = RSP_ADDR;
          cmd_nxt = RSP_CMD;
          status_nxt = RSP_STATUS;
          dlen_nxt = dlen_in;
          data_nxt = RSP_DATA;
          ofs_nxt = RCF_OFS_DELIM;
          ready_nxt = 1'b0;
          sum_clear = 1'b1;
          state_nxt = RCF_BODY;
          tx_valid_nxt = 1'b1;
          tx_byte_nxt = byte_sel;
          tx_last_nxt = 1'b0;
        end
      end
      RCF_BODY: begin
        if (sent) begin
          sum_add = (ofs_r >= RCF_OFS_TYPE);
          if (ofs_r == 8'(RCF_OFS_DATA + dlen_r - 8'h01) ||
              (dlen_r == 8'h00 && ofs_r == RCF_OFS_STATUS)) begin
            state_nxt = RCF_CSUM;
            tx_byte_nxt = 8'(csum - tx_byte_r);
            tx_last_nxt = 1'b1;
          end else begin
            ofs_nxt = 8'(ofs_r + 8'h01);
            tx_byte_nxt = byte_sel;
          end
        end
      end
      RCF_CSUM: begin
        if (sent) begin
          tx_valid_nxt = 1'b0;
          tx_last_nxt = 1'b0;
          ready_nxt = 1'b1;
          state_nxt = RCF_IDLE;
        end
      end
      default: begin
        state_nxt = RCF_IDLE;
        ready_nxt = 1'b1;
        tx_valid_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      state_r <= RCF_IDLE;
      ofs_r <= 8'h00;
      tag_r <= 8'h00;
      addr_r <= 64'h0;
      cmd_r <= 16'h0000;
      status_r <= 8'h00;
      dlen_r <= 8'h00;
      data_r <= '0;
      tx_valid_r <= 1'b0;
      tx_byte_r <= 8'h00;
      tx_last_r <= 1'b0;
      ready_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      ofs_r <= ofs_nxt;
      tag_r <= tag_nxt;
      addr_r <= addr_nxt;
      cmd_r <= cmd_nxt;
      status_r <= status_nxt;
      dlen_r <= dlen_nxt;
      data_r <= data_nxt;
      tx_valid_r <= tx_valid_nxt;
      tx_byte_r <= tx_byte_nxt;
      tx_last_r <= tx_last_nxt;
      ready_r <= ready_nxt;
    end
  end

  rcf_csum u_csum (
    .clk(SYS_CLK),
    .srst(SRST),
    .clear(sum_clear),
    .add(sum_add),
    .data(tx_byte_r),
    .sum(sum),
    .csum(csum)
  );

  assign RSP_READY = ready_r;
  assign TX_VALID = tx_valid_r;
  assign TX_BYTE = tx_byte_r;
  assign TX_LAST = tx_last_r;

  // Checks
  property p_delim;
    @(posedge SYS_CLK) disable iff (SRST)
      (RSP_VALID && RSP_READY) |=> (TX_VALID && TX_BYTE == RCF_DELIM);
  endproperty
  a_delim: assert property (p_delim) else $error("no delimiter");

  property p_type;
    @(posedge SYS_CLK) disable iff (SRST)
      (sent && state_r == RCF_BODY && ofs_r == RCF_OFS_LEN_LSB)
      |=> (TX_BYTE == RCF_TYPE);
  endproperty
  a_type: assert property (p_type) else $error("bad type");

  property p_one_frame;
    @(posedge SYS_CLK) disable iff (SRST)
      (TX_VALID && !TX_LAST) |-> !RSP_READY;
  endproperty
  a_one_frame: assert property (p_one_frame) else $error("merged");

  property p_len;
    @(posedge SYS_CLK) disable iff (SRST)
      (sent && ofs_r == RCF_OFS_LEN_MSB && state_r == RCF_BODY)
      |-> (TX_BYTE == len[15:8]) ##1 (TX_BYTE == len[7:0]);
  endproperty
  a_len: assert property (p_len) else $error("bad length");

  property p_tag;
    @(posedge SYS_CLK) disable iff (SRST)
      (sent && ofs_r == RCF_OFS_TYPE && state_r == RCF_BODY)
      |=> (TX_BYTE == tag_r);
  endproperty
  a_tag: assert property (p_tag) else $error("bad tag");

  property p_addr;
    @(posedge SYS_CLK) disable iff (SRST)
      (sent && ofs_r == RCF_OFS_TAG && state_r == RCF_BODY)
      |=> (TX_BYTE == addr_r[63:56]);
  endproperty
  a_addr: assert property (p_addr) else $error("bad address");

  property p_net;
    @(posedge SYS_CLK) disable iff (SRST)
      (TX_VALID && state_r == RCF_BODY && ofs_r == RCF_OFS_NET)
      |-> (TX_BYTE == RCF_NET_ADDR[15:8]);
  endproperty
  a_net: assert property (p_net) else $error("bad net addr");

  property p_status;
    @(posedge SYS_CLK) disable iff (SRST)
      (TX_VALID && state_r == RCF_BODY && ofs_r == RCF_OFS_STATUS)
      |-> (TX_BYTE == status_r);
  endproperty
  a_status: assert property (p_status) else $error("bad status");

  property p_csum;
    @(posedge SYS_CLK) disable iff (SRST)
      (TX_VALID && TX_LAST) |-> (8'(sum + TX_BYTE) == RCF_CSUM_BASE);
  endproperty
  a_csum: assert property (p_csum) else $error("bad checksum");
endmodule
`default_nettype wire

// file: rcf_pkg.sv
// Package of constants for the remote command response framer
`default_nettype none
package rcf_pkg;
  localparam logic [7:0] RCF_DELIM = 8'h7E;
  localparam logic [7:0] RCF_TYPE = 8'h97;
  localparam logic [15:0] RCF_NET_ADDR = 16'hFFFE;
  localparam logic [7:0] RCF_CSUM_BASE = 8'hFF;
  localparam logic [7:0] RCF_OFS_DELIM = 8'h00;
  localparam logic [7:0] RCF_OFS_LEN_MSB = 8'h01;
  localparam logic [7:0] RCF_OFS_LEN_LSB = 8'h02;
  localparam logic [7:0] RCF_OFS_TYPE = 8'h03;
  localparam logic [7:0] RCF_OFS_TAG = 8'h04;
  localparam logic [7:0] RCF_OFS_ADDR = 8'h05;
  localparam logic [7:0] RCF_OFS_NET = 8'h0D;
  localparam logic [7:0] RCF_OFS_CMD = 8'h0F;
  localparam logic [7:0] RCF_OFS_STATUS = 8'h11;
  localparam logic [7:0] RCF_OFS_DATA = 8'h12;
  // Bytes from type code through status
  localparam logic [15:0] RCF_FIXED_LEN = 16'h000F;
  localparam logic [7:0] RCF_ST_OK = 8'h00;
  localparam logic [7:0] RCF_ST_ERROR = 8'h01;
  localparam logic [7:0] RCF_ST_BAD_CMD = 8'h02;
  localparam logic [7:0] RCF_ST_BAD_PARAM = 8'h03;
endpackage
`default_nettype wire

// file: rcf_csum.sv
// Running modular sum and checksum byte for one frame
`default_nettype none
module rcf_csum
  import rcf_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic clear,
  input wire logic add,
  input wire logic [7:0] data,
  output logic [7:0] sum,
  output logic [7:0] csum
);
  logic [7:0] sum_r;
  logic [7:0] sum_nxt;

  always_comb begin
    sum_nxt = sum_r;
    if (clear) begin
      sum_nxt = 8'h00;
    end else if (add) begin
      sum_nxt = 8'(sum_r + data);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sum_r <= 8'h00;
    end else begin
      sum_r <= sum_nxt;
    end
  end

  assign sum = sum_r;
  assign csum = 8'(RCF_CSUM_BASE - sum_r);
endmodule
`default_nettype wire

// file: rcf_host_model.sv
// Host model: takes framed bytes from the framer and checks each checksum
`default_nettype none
module rcf_host_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic slow,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  input wire logic tx_last,
  output logic tx_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got[$];
  logic [7:0] sum_r;
  logic [1:0] ph_r;
  int idx_r;
  int frames;
  int bad_sums;
  always_ff @(posedge clk) begin
    if (srst) begin
      tx_ready <= 1'b0;
      ph_r <= 2'h0;
      sum_r <= 8'h00;
      idx_r <= 0;
      frames <= 0;
      bad_sums <= 0;
    end else begin
      ph_r <= ph_r + 2'h1;
      // A slow host accepts only one cycle in four
      tx_ready <= !slow || (ph_r == 2'h3);
      if (tx_valid && tx_ready) begin
        got.push_back(tx_byte);
        idx_r <= tx_last ? 0 : idx_r + 1;
        sum_r <= (idx_r >= 3) ? sum_r + tx_byte : 8'h00;
        if (tx_last) begin
          frames <= frames + 1;
          // Sum from type code through checksum must be all ones
          if (8'(sum_r + tx_byte) != 8'hFF) bad_sums <= bad_sums + 1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: remote_cmd_response_framer_tb.sv
// Testbench for the remote command response framer
`default_nettype none
module remote_cmd_response_framer_tb;
  import rcf_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DMAX = 8;
  logic SYS_CLK = 1'b0;
  logic SRST = 1'b1;
  logic RSP_VALID = 1'b0;
  logic RSP_READY;
  logic [7:0] RSP_TAG = 8'h00;
  logic [63:0] RSP_ADDR = 64'h0;
  logic [15:0] RSP_CMD = 16'h0000;
  logic [7:0] RSP_STATUS = 8'h00;
  logic [7:0] RSP_DATA_LEN = 8'h00;
  logic [8*DMAX-1:0] RSP_DATA = '0;
  logic TX_VALID;
  logic TX_READY;
  logic [7:0] TX_BYTE;
  logic TX_LAST;
  logic slow = 1'b0;
  int bad_count = 0;
  int n_checks = 0;
  int base = 0;

  initial forever #20 SYS_CLK = ~SYS_CLK;

  rcf_framer #(.DATA_MAX(DMAX)) uut (.SYS_CLK(SYS_CLK), .SRST(SRST),
    .RSP_VALID(RSP_VALID), .RSP_READY(RSP_READY), .RSP_TAG(RSP_TAG),
    .RSP_ADDR(RSP_ADDR), .RSP_CMD(RSP_CMD), .RSP_STATUS(RSP_STATUS),
    .RSP_DATA_LEN(RSP_DATA_LEN), .RSP_DATA(RSP_DATA), .TX_VALID(TX_VALID),
    .TX_READY(TX_READY), .TX_BYTE(TX_BYTE), .TX_LAST(TX_LAST));

  rcf_host_model host (.clk(SYS_CLK), .srst(SRST), .slow(slow),
    .tx_valid(TX_VALID), .tx_byte(TX_BYTE), .tx_last(TX_LAST),
    .tx_ready(TX_READY));

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check8(string name, logic [7:0] exp, logic [7:0] got);
    n_checks++;
    if (exp !== got) begin
      $display("ERROR %s expected %h seen %h", name, exp, got);
      bad_count++;
    end
  endtask

  // Offers one answer, waits for its frame and compares every byte
  task automatic send_and_check(logic [7:0] tag, logic [63:0] addr,
      logic [15:0] cmd, logic [7:0] st, int n, logic [8*DMAX-1:0] d);
    logic [7:0] e[$];
    logic [7:0] cs;
    logic [15:0] len;
    int f0;
    int k;
    len = RCF_FIXED_LEN + 16'(n);
    e = {RCF_DELIM, len[15:8], len[7:0], RCF_TYPE, tag};
    for (k = 7; k >= 0; k--) e.push_back(addr[8*k+:8]);
    e = {e, RCF_NET_ADDR[15:8], RCF_NET_ADDR[7:0], cmd[15:8], cmd[7:0], st};
    for (k = 0; k < n; k++) e.push_back(d[8*k+:8]);
    cs = 8'h00;
    for (k = 3; k < e.size(); k++) cs = cs + e[k];
    e.push_back(RCF_CSUM_BASE - cs);
    k = 0;
    while (RSP_READY !== 1'b1) begin
      @(negedge SYS_CLK);
      if (++k > 200) begin
        bad_count++;
        finish_test();
      end
    end
    f0 = host.frames;
    @(posedge SYS_CLK);
    RSP_VALID <= 1'b1;
    RSP_TAG <= tag;
    RSP_ADDR <= addr;
    RSP_CMD <= cmd;
    RSP_STATUS <= st;
    RSP_DATA_LEN <= 8'(n);
    RSP_DATA <= d;
    @(posedge SYS_CLK);
    RSP_VALID <= 1'b0;
    RSP_DATA <= ~d;
    RSP_ADDR <= ~addr;
    k = 0;
    @(negedge SYS_CLK);
    check8("ready in frame", 8'h00, {7'h00, RSP_READY});
    while (host.frames != f0 + 1) begin
      @(negedge SYS_CLK);
      if (++k > 500) begin
        bad_count++;
        finish_test();
      end
    end
    check8("ready after frame", 8'h01, {7'h00, RSP_READY});
    check8("frame size", 8'(e.size()), 8'(host.got.size() - base));
    for (k = 0; k < e.size(); k++)
      check8("frame byte", e[k], host.got[base+k]);
    check8("bad sums", 8'h00, 8'(host.bad_sums));
    base = host.got.size();
  endtask

  task automatic t_example();
    slow <= 1'b0;
    send_and_check(8'h55, 64'h0013A20040522BAA, 16'h534C, RCF_ST_OK, 4,
      64'hAA2B5240);
    check8("example checksum", 8'hF4, host.got[base-1]);
  endtask

  // Reset in mid-frame abandons the frame and leaves the framer idle
  task automatic t_mid_reset();
    @(posedge SYS_CLK);
    RSP_VALID <= 1'b1;
    RSP_DATA_LEN <= 8'h02;
    @(posedge SYS_CLK);
    RSP_VALID <= 1'b0;
    @(negedge SYS_CLK);
    check8("ready in frame", 8'h00, {7'h00, RSP_READY});
    check8("first byte", RCF_DELIM, TX_BYTE);
    repeat (4) @(posedge SYS_CLK);
    SRST <= 1'b1;
    repeat (2) @(posedge SYS_CLK);
    SRST <= 1'b0;
    @(negedge SYS_CLK);
    check8("ready after reset", 8'h01, {7'h00, RSP_READY});
    check8("valid after reset", 8'h00, {7'h00, TX_VALID});
    check8("last after reset", 8'h00, {7'h00, TX_LAST});
    check8("byte after reset", 8'h00, TX_BYTE);
    base = host.got.size();
  endtask

  // Several answers to one discovery query, back to back, each own frame
  task automatic t_status_sweep();
    int s;
    slow <= 1'b1;
    for (s = 0; s < 4; s++)
      send_and_check(8'h2A, 64'h0123456789ABCDEF, 16'h4E44, 8'(s), 0,
        '0);
  endtask

  task automatic t_full_data();
    slow <= 1'b1;
    send_and_check(8'hFF, 64'hFFFFFFFFFFFFFFFF, 16'h7A7A, RCF_ST_BAD_PARAM,
      DMAX, 64'hFEDCBA9876543210);
  endtask

  initial begin
    repeat (2) @(posedge SYS_CLK);
    SRST <= 1'b0;
    t_example();
    t_mid_reset();
    t_status_sweep();
    t_full_data();
    finish_test();
  end
endmodule
`default_nettype wire
